// ---- pt_pkg.sv ----
// Purpose: Constants and types for the 16-bit periodic timer
// Assumes: AXI4-Lite slave, 32-bit data, 12-bit byte address
// Notes: Register index times four gives the byte address
// Functional notes
// [RULE_01] Timer mode counts every clock cycle and returns to zero after matching the period.
// [RULE_02] Idle stops counting only when idle stop select is one; counting resumes after idle.
// [RULE_03] Synchronous counter mode resynchronises the pin clock and counts its rising edges.
// [RULE_04] Asynchronous counter mode counts pin rising edges without the synchroniser.
// [RULE_05] Gate accumulate enable counts clock cycles only while the gate pin is high.
// [RULE_06] Software enables gating together with timer on and the internal clock source.
// [RULE_07] The selected input is divided by 1, 8, 64 or 256 by the prescale select field.
// [RULE_08] The prescaler clears on a count write, on clearing timer on, and on reset. The code clears it on a count write only while timer on is one.
// [RULE_09] While timer on is zero the prescaler holds its value.
// [RULE_10] A control write never touches the count; only a count write changes it.
// [RULE_11] In sleep the timer counts only when on, external clock and no sync are chosen.
// [RULE_12] A period match requests an interrupt when the match interrupt enable is set.
// [RULE_13] Interrupt sources are the period match and, when gated, the gate falling edge.
// [RULE_14] The match flag stays set after a match until software clears it.
// [RULE_15] In gated mode a falling gate edge also sets the match flag.
// [RULE_16] Prescale codes 00, 01, 10, 11 mean divide by 1, 8, 64, 256.
// [RULE_17] Clock source one picks the pin; sync select one routes it via the synchroniser.
`default_nettype none
package pt_pkg;
    // ==========================================================
    // Register map
    localparam int PT_AW = 12;
    localparam logic [9:0] PT_IDX_COUNT = 10'h100;
    localparam logic [9:0] PT_IDX_PERIOD = 10'h102;
    localparam logic [9:0] PT_IDX_CTRL = 10'h104;
    localparam logic [9:0] PT_IDX_FLAG = 10'h106;
    localparam logic [15:0] PT_RST_COUNT = 16'h0000;
    localparam logic [15:0] PT_RST_PERIOD = 16'hffff;
    localparam logic [15:0] PT_RST_CTRL = 16'h0000;
    localparam logic [15:0] PT_CTRL_MASK = 16'ha076;
    // Flag register fields and AXI response codes
    localparam int PT_FLAG_BIT = 0;
    localparam int PT_IRQEN_BIT = 1;
    localparam logic [1:0] PT_RESP_OKAY = 2'b00;
    localparam logic [1:0] PT_RESP_SLVERR = 2'b10;
    // ==========================================================
    // Prescaler terminal counts
    localparam logic [7:0] PT_TERM_DIV1 = 8'h00;
    localparam logic [7:0] PT_TERM_DIV8 = 8'h07;
    localparam logic [7:0] PT_TERM_DIV64 = 8'h3f;
    localparam logic [7:0] PT_TERM_DIV256 = 8'hff;
    // ==========================================================
    // Types
    typedef struct packed {
        logic timer_on;
        logic rsv14;
        logic idle_stop_select;
        logic [5:0] rsv12_7;
        logic gate_accumulate_enable;
        logic [1:0] prescale_select;
        logic rsv3;
        logic external_sync_select;
        logic clock_source_select;
        logic rsv0;
    } pt_ctrl_s;
    typedef enum logic [1:0] {
        PT_MODE_TIMER = 2'b00,
        PT_MODE_GATED = 2'b01,
        PT_MODE_SYNC = 2'b11,
        PT_MODE_ASYNC = 2'b10
    } pt_mode_e;
endpackage
`default_nettype wire

// ---- pt_timer.sv ----
// Purpose: 16-bit periodic timer/counter with prescaler, gate and AXI4-Lite registers
// Assumes: Pin input synchronous to aclk; one clock cycle is one instruction cycle
// Notes: Asynchronous counter mode still samples the pin once on aclk
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module pt_timer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [pt_pkg::PT_AW-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [pt_pkg::PT_AW-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic gate_clock_pin,
    input wire logic cpu_idle,
    input wire logic cpu_sleep,
    output logic match_irq
);
    import pt_pkg::*;

    // ==========================================================
    // Register state
    logic [15:0] count_value_q;
    logic [15:0] period_value_q;
    pt_ctrl_s timer_control_q;
    logic match_flag_q;
    logic match_irq_enable_q;
    logic [7:0] ps_cnt_q;

    // ==========================================================
    // AXI write channel state
    logic aw_held_q;
    logic w_held_q;
    logic [PT_AW-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;

    // Accept each half once; no new write until the response leaves
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready = !w_held_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // Each half is held until its partner arrives, in either order
    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire = s_axi_wvalid && s_axi_wready;
    wire aw_have = aw_held_q || aw_fire;
    wire w_have = w_held_q || w_fire;
    wire wr_go = aw_have && w_have && !bvalid_q;
    wire [PT_AW-1:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
    wire [31:0] wr_data = w_held_q ? wdata_q : s_axi_wdata;
    wire [3:0] wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
    wire [9:0] wr_idx = wr_addr[PT_AW-1:2];

    // Write decode
    wire wr_count = wr_go && (wr_idx == PT_IDX_COUNT);
    wire wr_period = wr_go && (wr_idx == PT_IDX_PERIOD);
    wire wr_ctrl = wr_go && (wr_idx == PT_IDX_CTRL);
    wire wr_flag = wr_go && (wr_idx == PT_IDX_FLAG);
    wire wr_hit = wr_count || wr_period || wr_ctrl || wr_flag;
    wire [15:0] wr_bmask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

    // Byte-lane merge helper
    function automatic logic [15:0] pt_merge(input logic [15:0] old_v,
                                             input logic [15:0] new_v,
                                             input logic [15:0] m);
        pt_merge = (old_v & ~m) | (new_v & m);
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= PT_RESP_OKAY;
        end else begin
            if (aw_fire) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (w_fire) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            aw_held_q <= wr_go ? 1'b0 : aw_have;
            w_held_q <= wr_go ? 1'b0 : w_have;
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? PT_RESP_OKAY : PT_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Input path: sync chain for sync and gated modes, single sample for async mode
    logic pin_meta_q;
    logic pin_sync_q;
    logic pin_sync_d1_q;
    logic pin_raw_q;
    logic pin_raw_d1_q;

    // pin_meta_q feeds only pin_sync_q
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
            pin_sync_d1_q <= 1'b0;
            pin_raw_q <= 1'b0;
            pin_raw_d1_q <= 1'b0;
        end else begin
            pin_meta_q <= gate_clock_pin;
            pin_sync_q <= pin_meta_q;
            pin_sync_d1_q <= pin_sync_q;
            pin_raw_q <= gate_clock_pin;
            pin_raw_d1_q <= pin_raw_q;
        end
    end

    // ==========================================================
    // Mode and run decode
    pt_mode_e mode;
    assign mode = !timer_control_q.clock_source_select ?
                  (timer_control_q.gate_accumulate_enable ? PT_MODE_GATED : PT_MODE_TIMER) :
                  (timer_control_q.external_sync_select ? PT_MODE_SYNC : PT_MODE_ASYNC); // [RULE_17]

    // Halt qualifiers; only the unsynchronised pin clock survives sleep
    wire sleep_ok = timer_control_q.clock_source_select
                    && !timer_control_q.external_sync_select; // [RULE_11]
    wire idle_halt = cpu_idle && timer_control_q.idle_stop_select; // [RULE_02]
    wire sleep_halt = cpu_sleep && !sleep_ok; // [RULE_11]
    wire run = timer_control_q.timer_on && !idle_halt && !sleep_halt;

    // Detectors reset low, the idle pin level, so no false edge follows reset
    wire sync_rise = pin_sync_q && !pin_sync_d1_q; // [RULE_03]
    wire raw_rise = pin_raw_q && !pin_raw_d1_q; // [RULE_04]
    wire gate_fall = !pin_sync_q && pin_sync_d1_q;

    // Raw input event before prescaling
    logic in_evt;
    always_comb begin
        in_evt = 1'b0;
        unique case (mode)
            PT_MODE_TIMER: in_evt = 1'b1; // [RULE_01]
            PT_MODE_GATED: in_evt = pin_sync_q; // [RULE_05]
            PT_MODE_SYNC: in_evt = sync_rise; // [RULE_03]
            PT_MODE_ASYNC: in_evt = raw_rise; // [RULE_04]
        endcase
    end

    // ==========================================================
    // Prescaler
    logic [7:0] ps_term;
    always_comb begin
        ps_term = PT_TERM_DIV1;
        unique case (timer_control_q.prescale_select) // [RULE_16]
            2'b00: ps_term = PT_TERM_DIV1;
            2'b01: ps_term = PT_TERM_DIV8;
            2'b10: ps_term = PT_TERM_DIV64;
            2'b11: ps_term = PT_TERM_DIV256;
        endcase
    end

    // Tick is a one-cycle enable; the count never sees a slower clock
    wire ps_evt = run && in_evt;
    wire tick = ps_evt && (ps_cnt_q >= ps_term); // [RULE_07]
    wire ctrl_on_next = wr_bmask[15] ? wr_data[15] : timer_control_q.timer_on;
    wire turn_off = wr_ctrl && timer_control_q.timer_on && !ctrl_on_next;
    // Halted prescaler clock: clears only land while the timer is on
    wire ps_clear = timer_control_q.timer_on && (wr_count || turn_off); // [RULE_08] [RULE_09]

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ps_cnt_q <= 8'h00; // [RULE_08]
        end else if (ps_clear) begin
            ps_cnt_q <= 8'h00; // [RULE_08]
        end else if (tick) begin
            ps_cnt_q <= 8'h00;
        end else if (ps_evt) begin
            ps_cnt_q <= ps_cnt_q + 8'h01;
        end
    end

    // ==========================================================
    // Count, period and control
    wire at_period = (count_value_q == period_value_q);
    wire match_evt = tick && at_period; // [RULE_13]
    wire gate_evt = timer_control_q.timer_on && (mode == PT_MODE_GATED) && gate_fall; // [RULE_15]
    wire [15:0] count_inc = at_period ? 16'h0000 : count_value_q + 16'h0001; // [RULE_01]

    // Software write beats a same-cycle increment
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_value_q <= PT_RST_COUNT;
        end else if (wr_count) begin
            count_value_q <= pt_merge(count_value_q, wr_data[15:0], wr_bmask); // [RULE_10]
        end else if (tick) begin
            count_value_q <= count_inc; // [RULE_01] [RULE_11]
        end
    end

    // Period and control change only through a bus write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            period_value_q <= PT_RST_PERIOD;
            timer_control_q <= pt_ctrl_s'(PT_RST_CTRL);
            match_irq_enable_q <= 1'b0;
        end else begin
            if (wr_period) begin
                period_value_q <= pt_merge(period_value_q, wr_data[15:0], wr_bmask);
            end
            if (wr_ctrl) begin
                timer_control_q <= pt_ctrl_s'(pt_merge(16'(timer_control_q),
                                   wr_data[15:0] & PT_CTRL_MASK, wr_bmask)); // [RULE_10]
            end
            if (wr_flag && wr_strb[0]) begin
                match_irq_enable_q <= wr_data[PT_IRQEN_BIT];
            end
        end
    end

    // Sticky flag; hardware set wins over a write-one-to-clear
    wire flag_clr = wr_flag && wr_strb[0] && wr_data[PT_FLAG_BIT];
    wire flag_set = match_evt || gate_evt; // [RULE_13] [RULE_15]
    wire match_flag_d = flag_set ? 1'b1 : (flag_clr ? 1'b0 : match_flag_q); // [RULE_14]
    wire irq_enable_d = (wr_flag && wr_strb[0]) ? wr_data[PT_IRQEN_BIT] : match_irq_enable_q;
    logic match_irq_q;

    // Request built from next values, so it tracks the flag in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            match_flag_q <= 1'b0;
            match_irq_q <= 1'b0;
        end else begin
            match_flag_q <= match_flag_d; // [RULE_14] [RULE_15]
            match_irq_q <= match_flag_d && irq_enable_d; // [RULE_12]
        end
    end

    // Flop-driven request; no decode glitch reaches the interrupt input
    assign match_irq = match_irq_q; // [RULE_12]

    // ==========================================================
    // AXI read channel
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    wire ar_fire = s_axi_arvalid && s_axi_arready;
    // Read decode; unmapped words answer with an error and zero data
    wire [9:0] rd_idx = s_axi_araddr[PT_AW-1:2];
    wire rd_count = (rd_idx == PT_IDX_COUNT);
    wire rd_period = (rd_idx == PT_IDX_PERIOD);
    wire rd_ctrl = (rd_idx == PT_IDX_CTRL);
    wire rd_flag = (rd_idx == PT_IDX_FLAG);
    wire rd_hit = rd_count || rd_period || rd_ctrl || rd_flag;
    wire [15:0] rd_flagword = {14'h0000, match_irq_enable_q, match_flag_q};
    wire [15:0] rd_word = rd_count ? count_value_q :
                          rd_period ? period_value_q :
                          rd_ctrl ? 16'(timer_control_q) :
                          rd_flag ? rd_flagword : 16'h0000;

    // One-cycle read latency, data held until taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= PT_RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_q <= 1'b1;
            rdata_q <= {16'h0000, rd_word};
            rresp_q <= rd_hit ? PT_RESP_OKAY : PT_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Protection bits are accepted and ignored
    wire unused_ok = ^{s_axi_awprot, s_axi_arprot, wr_data[31:16], wr_strb[3:2]};
endmodule
`default_nettype wire

// ---- pt_timer_asserts.sv ----
// Purpose: Port-level checks for the periodic timer
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to pt_timer from the bench top
`timescale 1ns/1ns
`default_nettype none
module pt_timer_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic match_irq
);
    // ==========================================================
    // Handshake and interrupt checks
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Both write halves taken in one cycle
    wire both_in = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    write_answer_a: assert property (both_in |=> s_axi_bvalid)
        else $error("write response missing");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data missing");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed while waiting");
    read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready && s_axi_rdata[31:16] == 16'h0000)
        else $error("read accepted while data pending");
    // Interrupt request only falls through a register write, never on its own
    flag_sticky_a: assert property (match_irq |=> match_irq || $rose(s_axi_bvalid))
        else $error("interrupt dropped without a write");
    irq_reset_a: assert property ($rose(aresetn) |-> !match_irq)
        else $error("interrupt high after reset");
    cover property ($rose(match_irq));
    cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
    cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule
`default_nettype wire

// ---- pt_pin_model.sv ----
// Purpose: Pin source standing in for the external clock or gate
// Assumes: Pin changes just after a rising aclk edge
// Notes: Toggles only while run is high, else holds level
`timescale 1ns/1ns
`default_nettype none
module pt_pin_model #(parameter int HALF = 2) (
    input wire logic aclk,
    input wire logic run,
    input wire logic level,
    output logic pin
);
    logic [7:0] cnt_q = 8'h00;
    logic pin_q = 1'b0;
    // One procedural driver; the port only mirrors it
    assign pin = pin_q;
    // ==========================================================
    // Clock or gate waveform; HALF sets how slow the clock runs
    always @(posedge aclk) begin
        if (!run) begin
            cnt_q <= 8'h00;
            pin_q <= level;
        end else if (cnt_q == 8'(HALF - 1)) begin
            cnt_q <= 8'h00;
            pin_q <= ~pin_q;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ---- test_periodic_timer_16bit.sv ----
// Purpose: Self-checking bench for the periodic timer
// Assumes: 20 MHz clock, reset held two cycles
// Notes: Counts are checked in windows that absorb bus latency
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module test_periodic_timer_16bit;
    import pt_pkg::*;
    localparam logic [11:0] A_CNT = {PT_IDX_COUNT, 2'b00}, A_PER = {PT_IDX_PERIOD, 2'b00};
    localparam logic [11:0] A_CTL = {PT_IDX_CTRL, 2'b00}, A_FLG = {PT_IDX_FLAG, 2'b00};
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic gate_clock_pin, cpu_idle, cpu_sleep, match_irq, pin_run, pin_level;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] v;
    int err_count, checks, i, n;
    int sh[4] = '{0, 3, 6, 8};
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    pt_timer DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .gate_clock_pin, .cpu_idle, .cpu_sleep, .match_irq);
    pt_pin_model #(.HALF(2)) u_pin (.aclk, .run(pin_run), .level(pin_level), .pin(gate_clock_pin));
    // ==========================================================
    // Bus tasks; each holds its request until accepted, then waits for the answer edge
    task automatic final_report();
        $display("checks=%0d errors=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] e);
        int k;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        if (k == 40) begin
            err_count++;
            final_report();
        end
        `CHK(s_axi_bresp, e)
    endtask
    task automatic rd(input logic [11:0] a, input logic [1:0] e, output logic [15:0] d);
        int k;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        if (k == 40) begin
            err_count++;
            final_report();
        end
        `CHK(s_axi_rresp, e)
        d = s_axi_rdata[15:0];
    endtask
    task automatic rc(input logic [11:0] a, input logic [15:0] x);
        rd(a, PT_RESP_OKAY, v);
        `CHK(v, x)
    endtask
    // Run the timer for cyc cycles from zero, stop it, check the count window
    task automatic ms(input logic [15:0] ctl, input int cyc, input int lo, input int hi);
        wr(A_CNT, 16'h0000, PT_RESP_OKAY);
        wr(A_CTL, ctl, PT_RESP_OKAY);
        repeat (cyc) @(posedge aclk);
        wr(A_CTL, 16'h0000, PT_RESP_OKAY);
        rd(A_CNT, PT_RESP_OKAY, v);
        `CHK((v >= 16'(lo)) && (v <= 16'(hi)), 1'b1)
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {cpu_idle, cpu_sleep, pin_run, pin_level} = '0;
        err_count = 0;
        checks = 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rc(A_CNT, PT_RST_COUNT);
        rc(A_PER, PT_RST_PERIOD);
        rc(A_CTL, PT_RST_CTRL);
        rc(A_FLG, 16'h0000);
        rd(12'h7fc, PT_RESP_SLVERR, v);
        wr(12'h7fc, 16'h0001, PT_RESP_SLVERR);
        wr(A_CNT, 16'h1234, PT_RESP_OKAY);
        wr(A_CTL, 16'h0030, PT_RESP_OKAY);
        rc(A_CTL, 16'h0030);
        wr(A_CTL, 16'h5f89, PT_RESP_OKAY);
        rc(A_CTL, 16'h0000);
        rc(A_CNT, 16'h1234);
        // Every prescale code over one window of 512 cycles
        for (i = 0; i < 4; i++) begin
            ms(16'h8000 | {10'h000, i[1:0], 4'h0}, 512, 512 >> sh[i], (518 >> sh[i]) + 1);
        end
        // Count write six events into a divide-by-8 phase restarts it; no tick follows
        wr(A_CNT, 16'h0000, PT_RESP_OKAY);
        wr(A_CTL, 16'h8010, PT_RESP_OKAY);
        repeat (4) @(posedge aclk);
        wr(A_CNT, 16'h0000, PT_RESP_OKAY);
        repeat (3) @(posedge aclk);
        wr(A_CTL, 16'h0000, PT_RESP_OKAY);
        rc(A_CNT, 16'h0000);
        cpu_idle <= 1'b1;
        ms(16'ha000, 100, 0, 0);
        ms(16'h8000, 100, 100, 106);
        cpu_idle <= 1'b0;
        pin_run <= 1'b1;
        ms(16'h8006, 80, 19, 22);
        cpu_sleep <= 1'b1;
        ms(16'h8000, 80, 0, 0);
        ms(16'h8006, 80, 0, 0);
        ms(16'h8002, 80, 19, 22);
        cpu_sleep <= 1'b0;
        pin_run <= 1'b0;
        ms(16'h8040, 40, 0, 0);
        wr(A_FLG, 16'h0003, PT_RESP_OKAY);
        pin_level <= 1'b1;
        ms(16'h8040, 30, 28, 36);
        wr(A_CNT, 16'h0000, PT_RESP_OKAY);
        wr(A_CTL, 16'h8040, PT_RESP_OKAY);
        repeat (20) @(posedge aclk);
        pin_level <= 1'b0;
        repeat (10) @(posedge aclk);
        `CHK(match_irq, 1'b1)
        wr(A_FLG, 16'h0003, PT_RESP_OKAY);
        wr(A_CTL, 16'h0000, PT_RESP_OKAY);
        `CHK(match_irq, 1'b0)
        wr(A_PER, 16'h0003, PT_RESP_OKAY);
        wr(A_CNT, 16'h0000, PT_RESP_OKAY);
        wr(A_CTL, 16'h8000, PT_RESP_OKAY);
        for (n = 0; n < 20 && match_irq !== 1'b1; n++) @(posedge aclk);
        `CHK(match_irq, 1'b1)
        wr(A_CTL, 16'h0000, PT_RESP_OKAY);
        rd(A_CNT, PT_RESP_OKAY, v);
        `CHK(v <= 16'h0003, 1'b1)
        `CHK(match_irq, 1'b1)
        wr(A_FLG, 16'h0000, PT_RESP_OKAY);
        `CHK(match_irq, 1'b0)
        rc(A_FLG, 16'h0001);
        wr(A_FLG, 16'h0001, PT_RESP_OKAY);
        rc(A_FLG, 16'h0000);
        // Mid-run reset with the timer running and the request raised
        wr(A_FLG, 16'h0002, PT_RESP_OKAY);
        wr(A_CNT, 16'h0000, PT_RESP_OKAY);
        wr(A_CTL, 16'h8000, PT_RESP_OKAY);
        repeat (10) @(posedge aclk);
        `CHK(match_irq, 1'b1)
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        `CHK(match_irq, 1'b0)
        rc(A_CTL, PT_RST_CTRL);
        rc(A_PER, PT_RST_PERIOD);
        rc(A_CNT, PT_RST_COUNT);
        rc(A_FLG, 16'h0000);
        final_report();
    end
endmodule
bind pt_timer pt_timer_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .match_irq);
`default_nettype wire
